// [rtl/tbo_pkg.sv]
/*
 * Shared constants and types for the trace bus output port.
 * Assumes a single system clock i_clk; the link clock arrives as a sampled input.
 */
package tbo_pkg;
   localparam int          DATA_W        = 32;
   localparam int          ID_W          = 7;
   localparam int          BYTES_W       = 2;
   localparam int          SYNC_STAGES   = 3;
   localparam logic [31:0] DATA_RST      = 32'h0000_0000;
   localparam logic [6:0]  ID_RST        = 7'h00;
   localparam logic [1:0]  BYTES_RST     = 2'h0;
   localparam logic [1:0]  BYTES_FOUR    = 2'h3;
   localparam int          SRC_DEPTH     = 4;
   typedef logic [DATA_W-1:0] tbo_data_t;
   typedef logic [ID_W-1:0]   tbo_id_t;
   typedef logic [BYTES_W-1:0] tbo_bytes_t;
   typedef enum logic [1:0] {TBO_IDLE, TBO_SEND, TBO_FLUSH_ACK} tbo_state_e;
endpackage : tbo_pkg

// [rtl/tbo_src_if.sv]
/*
 * Source-side word channel between the capture logic and the link engine.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface tbo_src_if;
   import tbo_pkg::*;
   logic       valid;
   logic       ready;
   tbo_data_t  data;
   tbo_bytes_t bytes;
   tbo_id_t    id;
   modport producer (output valid, output data, output bytes, output id, input ready);
   modport consumer (input valid, input data, input bytes, input id, output ready);
endinterface : tbo_src_if

// [rtl/tbo_sync.sv]
/*
 * Three-stage synchroniser with agreement filter for one link-side level.
 * Assumes the input is asynchronous to i_clk.
 */
`timescale 1ns/1ps
module tbo_sync (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_async,
   output logic      o_level
);
   import tbo_pkg::*;
   logic [SYNC_STAGES-1:0] stage;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         stage <= '0;
      end else begin
         stage <= {stage[SYNC_STAGES-2:0], i_async};
      end
   end

   // Level changes only when the second and third stages agree
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_level <= 1'b0;
      end else if (stage[1] == stage[2]) begin
         o_level <= stage[2];
      end
   end
endmodule : tbo_sync

// [rtl/tbo_port.sv]
/*
 * Trace bus output port: presents trace words with byte count and source tag
 * on a valid/ready link and answers flush requests from the sink.
 * Assumes the link clock, clock enable, ready and flush request come from the sink's
 * domain and are resampled here; link-side outputs change only after an enabled link edge or a link reset.
 */
// Functional notes
// RQ1: Valid is high only while the data bus holds a real word and is low in reset.
// RQ2: The sink raises ready to accept the word presented and lowers it when not ready.
// RQ3: Byte count is encoded b00 for one byte up to b11 for four and resets to b00.
// RQ4: A 7-bit source tag and 32-bit data word are presented and are zero in reset.
// RQ5: The sink raises flush request to ask for buffered data to be drained.
// RQ6: Flush ready stays low until the buffer is flushed, then rises; it resets low.
// RQ7: Port logic advances on enabled link clock edges only and holds otherwise.
// RQ8: A word moves on an enabled edge with valid and ready high; outputs hold while stalled.
`timescale 1ns/1ps
module tbo_port #(
   parameter int DEPTH = tbo_pkg::SRC_DEPTH
) (
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   input  wire logic              i_link_clk,
   input  wire logic              i_link_clk_en,
   input  wire logic              i_link_rst_n,
   input  wire logic              i_ready,
   input  wire logic              i_flush_req,
   input  wire logic              i_word_valid,
   input  wire tbo_pkg::tbo_data_t  i_word_data,
   input  wire tbo_pkg::tbo_bytes_t i_word_bytes,
   input  wire tbo_pkg::tbo_id_t    i_word_id,
   output logic                   o_word_ready,
   output logic                   o_valid,
   output tbo_pkg::tbo_data_t     o_data,
   output tbo_pkg::tbo_bytes_t    o_bytes,
   output tbo_pkg::tbo_id_t       o_id,
   output logic                   o_flush_ready
);
   import tbo_pkg::*;

   localparam int PW = $clog2(DEPTH);

   tbo_src_if src ();
   logic       lclk_s, lclk_d, ready_s, flush_s, lrst_n_s, en_s, lclk_rise;
   tbo_state_e state;
   tbo_data_t  mem_data  [DEPTH];
   tbo_bytes_t mem_bytes [DEPTH];
   tbo_id_t    mem_id    [DEPTH];
   logic [PW:0] wr_ptr, rd_ptr;
   logic        full, empty, take, pop, adv, link_rst;

   tbo_sync u_lclk  (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_link_clk),    .o_level(lclk_s));
   tbo_sync u_ready (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_ready),       .o_level(ready_s));
   tbo_sync u_flush (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_flush_req),   .o_level(flush_s));
   tbo_sync u_lrst  (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_link_rst_n),  .o_level(lrst_n_s));
   tbo_sync u_en    (.i_clk(i_clk), .i_rst(i_rst), .i_async(i_link_clk_en), .o_level(en_s));

   assign src.valid = i_word_valid;
   assign src.data  = i_word_data;
   assign src.bytes = i_word_bytes;
   assign src.id    = i_word_id;
   assign o_word_ready = src.ready;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         lclk_d <= 1'b0;
      end else begin
         lclk_d <= lclk_s;
      end
   end

   assign lclk_rise = lclk_s & ~lclk_d;
   assign adv       = lclk_rise & en_s;            // [RQ7]
   assign link_rst  = ~lrst_n_s;
   assign full      = (wr_ptr[PW-1:0] == rd_ptr[PW-1:0]) && (wr_ptr[PW] != rd_ptr[PW]);
   assign empty     = (wr_ptr == rd_ptr);
   // Back-pressure reaches the capture side while full or in link reset
   assign src.ready = ~full & ~link_rst;
   assign take      = src.valid & src.ready;
   // Transfer completes when an enabled edge sees valid and ready together
   assign pop       = adv & o_valid & ready_s;     // [RQ8] [RQ2]

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wr_ptr <= '0;
      end else if (link_rst) begin
         wr_ptr <= '0;
      end else if (take) begin
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   // Storage has no reset: a slot is only read after the write pointer has passed it
   always_ff @(posedge i_clk) begin
      if (take) begin
         mem_data[wr_ptr[PW-1:0]]  <= src.data;
         mem_bytes[wr_ptr[PW-1:0]] <= src.bytes;
         mem_id[wr_ptr[PW-1:0]]    <= src.id;
      end
   end

   // Output stage: loads only on enabled edges, holds while stalled
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rd_ptr  <= '0;
         o_valid <= 1'b0;                          // [RQ1]
         o_data  <= DATA_RST;                      // [RQ4]
         o_id    <= ID_RST;                        // [RQ4]
         o_bytes <= BYTES_RST;                     // [RQ3]
      end else if (link_rst) begin
         rd_ptr  <= '0;
         o_valid <= 1'b0;
         o_data  <= DATA_RST;
         o_id    <= ID_RST;
         o_bytes <= BYTES_RST;
      end else if (adv && (!o_valid || pop)) begin // [RQ8]
         if (!empty) begin
            o_valid <= 1'b1;                       // [RQ1]
            o_data  <= mem_data[rd_ptr[PW-1:0]];
            o_bytes <= mem_bytes[rd_ptr[PW-1:0]];  // [RQ3]
            o_id    <= mem_id[rd_ptr[PW-1:0]];
            rd_ptr  <= rd_ptr + 1'b1;
         end else begin
            o_valid <= 1'b0;                       // [RQ1]
         end
      end
   end

   // Flush: drain buffered words, then acknowledge for one enabled link edge
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state         <= TBO_IDLE;
         o_flush_ready <= 1'b0;                    // [RQ6]
      end else if (link_rst) begin
         state         <= TBO_IDLE;
         o_flush_ready <= 1'b0;
      end else if (adv) begin                      // [RQ7]
         case (state)
            TBO_IDLE: begin
               o_flush_ready <= 1'b0;
               if (flush_s) begin                  // [RQ5]
                  state <= TBO_SEND;
               end
            end
            TBO_SEND: begin
               if (empty && (!o_valid || pop)) begin
                  state         <= TBO_FLUSH_ACK;
                  o_flush_ready <= 1'b1;           // [RQ6]
               end
            end
            TBO_FLUSH_ACK: begin
               o_flush_ready <= 1'b0;
               state         <= TBO_IDLE;
            end
            default: begin
               state         <= TBO_IDLE;
               o_flush_ready <= 1'b0;
            end
         endcase
      end
   end

   // Assertions
   property p_valid_stall_hold;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      (o_valid && !pop) |=> (o_valid && $stable(o_data) && $stable(o_bytes) && $stable(o_id));
   endproperty
   a_valid_stall_hold: assert property (p_valid_stall_hold) else $error("stalled word changed"); // [RQ8]

   property p_hold_without_enable;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      !adv |=> ($stable(o_valid) && $stable(o_flush_ready) && $stable(state));
   endproperty
   a_hold_without_enable: assert property (p_hold_without_enable) else $error("moved without enable"); // [RQ7]

   property p_flush_ack_after_empty;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      $rose(o_flush_ready) |-> ($past(state) == TBO_SEND) && $past(empty);
   endproperty
   a_flush_ack_after_empty: assert property (p_flush_ack_after_empty) else $error("early flush ack"); // [RQ6]

   property p_valid_only_with_word;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      $rose(o_valid) |-> $past(adv) && !$past(empty);
   endproperty
   a_valid_only_with_word: assert property (p_valid_only_with_word) else $error("valid without word"); // [RQ1]

   property p_reset_values;
      @(posedge i_clk) i_rst |=> (!o_valid && o_data == DATA_RST && o_id == ID_RST
                                         && o_bytes == BYTES_RST && !o_flush_ready);
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad reset values"); // [RQ4]

   property p_bytes_from_source;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      $rose(o_valid) |-> o_bytes == $past(mem_bytes[rd_ptr[PW-1:0]]);
   endproperty
   a_bytes_from_source: assert property (p_bytes_from_source) else $error("byte count wrong"); // [RQ3]

   property p_pop_needs_ready;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      (o_valid && adv && !ready_s) |=> o_valid && $stable(o_data);
   endproperty
   a_pop_needs_ready: assert property (p_pop_needs_ready) else $error("word lost without ready"); // [RQ2]

   property p_flush_ack_one_edge;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      (o_flush_ready && adv) |=> !o_flush_ready;
   endproperty
   a_flush_ack_one_edge: assert property (p_flush_ack_one_edge) else $error("ack held too long"); // [RQ6]

   property p_data_hold_without_enable;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      !adv |=> ($stable(o_data) && $stable(o_bytes) && $stable(o_id));
   endproperty
   a_data_hold_without_enable: assert property (p_data_hold_without_enable) else $error("word moved"); // [RQ7]

   // Flush ack must stay low for the whole drain
   property p_flush_ready_low_in_send;
      @(posedge i_clk) disable iff (i_rst || link_rst)
      (state == TBO_SEND) |-> !o_flush_ready;
   endproperty
   a_flush_ready_low_in_send: assert property (p_flush_ready_low_in_send) else $error("ack while draining"); // [RQ6]

   property p_link_reset_clears;
      @(posedge i_clk) disable iff (i_rst)
      link_rst |=> (!o_valid && !o_flush_ready && o_data == DATA_RST && o_id == ID_RST
                    && o_bytes == BYTES_RST);
   endproperty
   a_link_reset_clears: assert property (p_link_reset_clears) else $error("link reset left state"); // [RQ1]
endmodule : tbo_port

// [sim/tbo_sink_model.sv]
/* Trace sink model: link clock, enable, ready, flush request.
   Assumes i_rand changes each system clock. */
`timescale 1ns/1ps
module tbo_sink_model (
   input  wire logic        i_go_flush,
   input  wire logic [31:0] i_rand,
   output logic             o_link_clk,
   output logic             o_link_clk_en,
   output logic             o_ready,
   output logic             o_flush_req
);
   initial begin
      o_link_clk    = 1'b0;
      o_link_clk_en = 1'b0;
      o_ready       = 1'b0;
      o_flush_req   = 1'b0;
   end
   always #160 o_link_clk = ~o_link_clk;
   // Change mid-period so the port sees settled levels at each rising edge
   always @(negedge o_link_clk) begin
      o_ready       <= i_rand[0] | i_rand[1];
      o_link_clk_en <= i_rand[2] | i_rand[3];
      o_flush_req   <= i_go_flush;
   end
endmodule : tbo_sink_model

// [sim/tb_trace_bus_output_port.sv]
/* Testbench of the trace bus output port with a random sink.
   Assumes tbo_pkg and the sink model are compiled first. */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module tb_trace_bus_output_port;
   import tbo_pkg::*;
   logic        i_clk = 0, i_rst = 1, i_link_rst_n = 0, i_word_valid = 0;
   logic        go_flush = 0, gen = 0, prev_hold = 0, prev_off = 0, prev_fr = 0;
   tbo_data_t   i_word_data = '0, o_data;
   tbo_bytes_t  i_word_bytes = '0, o_bytes;
   tbo_id_t     i_word_id = '0, o_id;
   logic        link_clk, link_en, ready, flush_req;
   logic        o_word_ready, o_valid, o_flush_ready;
   logic [31:0] rnd = 32'h2b;
   logic [41:0] prev = '0;
   logic [40:0] expq[$];
   int          n_mismatch = 0, samples_checked = 0, ncap = 0, k, n;
   always #20 i_clk = ~i_clk;
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Corner words first, then random ones
   function automatic logic [40:0] word_of(input int i, input logic [31:0] r);
      case (i)
         0: return {2'h3, 7'h7f, 32'hffff_ffff};
         1: return '0;
         2: return {2'h1, 7'h2a, 32'h8000_0001};
         3: return {2'h2, 7'h55, 32'h0000_00ff};
         default: return {r[28:27], r[26:20], r ^ 32'h5a5a_0f0f};
      endcase
   endfunction : word_of
   tbo_sink_model u_tbo_sink_model (.i_go_flush(go_flush), .i_rand(rnd),
      .o_link_clk(link_clk), .o_link_clk_en(link_en), .o_ready(ready),
      .o_flush_req(flush_req));
   tbo_port u_tbo_port (.i_clk(i_clk), .i_rst(i_rst), .i_link_clk(link_clk),
      .i_link_clk_en(link_en), .i_link_rst_n(i_link_rst_n), .i_ready(ready),
      .i_flush_req(flush_req), .i_word_valid(i_word_valid),
      .i_word_data(i_word_data), .i_word_bytes(i_word_bytes),
      .i_word_id(i_word_id), .o_word_ready(o_word_ready), .o_valid(o_valid),
      .o_data(o_data), .o_bytes(o_bytes), .o_id(o_id),
      .o_flush_ready(o_flush_ready));
   // Capture driver holds a refused word until it is taken
   always @(posedge i_clk) begin
      rnd <= xs(rnd);
      if (i_word_valid && o_word_ready) begin
         expq.push_back({i_word_bytes, i_word_id, i_word_data});
         ncap++;
      end
      if (!(i_word_valid && !o_word_ready)) begin
         i_word_valid <= gen & rnd[4];
         {i_word_bytes, i_word_id, i_word_data} <= word_of(ncap, rnd);
      end
   end
   // Link monitor: transfers and stalls judged at the link pin edge
   always @(posedge link_clk) if (i_link_rst_n && !i_rst) begin
      if (prev_hold || prev_off) `CHK({o_valid, o_bytes, o_id, o_data}, prev)
      if (prev_off) `CHK(o_flush_ready, prev_fr)
      if (o_valid && link_en && ready) begin
         if (expq.size() == 0) `CHK(o_valid, 1'b0)
         else `CHK({o_bytes, o_id, o_data}, expq.pop_front())
      end
      prev_hold <= o_valid && !(link_en && ready);
      prev_off  <= !link_en;
      prev_fr   <= o_flush_ready;
      prev      <= {o_valid, o_bytes, o_id, o_data};
   end else begin
      // Link reset wipes the port, so nothing held before it is expected after
      prev_hold <= 1'b0;
      prev_off  <= 1'b0;
   end
   task automatic end_of_test;
      $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst <= 1'b0;
      @(negedge i_clk);
      `CHK({o_valid, o_flush_ready}, 2'h0)
      `CHK({o_bytes, o_id, o_data}, 41'h0)
      @(posedge i_clk);
      i_link_rst_n <= 1'b1;
      gen          <= 1'b1;
      for (k = 0; k < 3; k++) begin
         repeat (1500) @(posedge i_clk);
         gen <= 1'b0;
         for (n = 0; n < 400 && i_word_valid; n++) @(posedge i_clk);
         if (i_word_valid) begin
            n_mismatch++;
            end_of_test();
         end
         go_flush <= 1'b1;
         for (n = 0; n < 2000 && o_flush_ready !== 1'b1; n++) @(negedge i_clk);
         `CHK(o_flush_ready, 1'b1)
         `CHK(expq.size() == 0, 1'b1)
         if (o_flush_ready !== 1'b1) end_of_test();
         @(posedge i_clk);
         go_flush <= 1'b0;
         if (k == 1) begin
            // Mid-run link reset: outputs and ack clear, capture side is refused
            i_link_rst_n <= 1'b0;
            repeat (20) @(posedge i_clk);
            @(negedge i_clk);
            `CHK({o_word_ready, o_valid, o_flush_ready}, 3'h0)
            `CHK({o_bytes, o_id, o_data}, 41'h0)
            @(posedge i_clk);
            i_link_rst_n <= 1'b1;
         end
         gen      <= 1'b1;
      end
      end_of_test();
   end
endmodule : tb_trace_bus_output_port
